//--- design/uip_core.v
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "uip_regs.vh"
module uip_core #(
  parameter DEPTH_LOG = 6
) (
  input wire clk_sys,
  input wire rstn,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire rx_valid,
  input wire [7:0] rx_char,
  input wire [2:0] rx_errs,
  input wire rx_overrun,
  input wire rx_stale,
  input wire tx_fifo_trig,
  input wire tx_empty,
  input wire [3:0] modem_pins_n,
  input wire rts_pin_n,
  input wire cts_pin_n,
  input wire flow_char_done,
  output reg flow_char_req,
  output reg [7:0] flow_char,
  output reg irq,
  output reg txd,
  output reg rts_n,
  output reg dtr_n,
  output reg rx_dma_request_n,
  output reg tx_dma_request_n
);
  localparam DEPTH = 1 << DEPTH_LOG;
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] irq_enable_reg;
  reg [7:0] fifo_ctrl_reg;
  reg [7:0] line_ctrl_reg;
  reg [7:0] modem_ctrl_reg;
  reg [7:0] enhanced_feature_reg;
  reg [7:0] flow_threshold_reg;
  reg [7:0] fifo_trigger_reg;
  reg [7:0] divisor_low_byte;
  reg [7:0] divisor_high_byte;
  reg [7:0] scratch_reg;
  reg [7:0] resume_char_one;
  reg [7:0] halt_char_one;
  reg [3:0] modem_chg_reg;
  reg [3:0] pin_s1_reg;
  reg [3:0] pin_s2_reg;
  reg [1:0] fc_s1_reg;
  reg [1:0] fc_s2_reg;
  reg [1:0] fc_d_reg;
  reg overrun_reg;
  reg tx_pend_reg;
  reg halt_pend_reg;
  reg spec_pend_reg;
  reg pin_pend_reg;
  reg [10:0] mem [0:DEPTH-1];
  reg [DEPTH_LOG-1:0] wr_ptr_reg;
  reg [DEPTH_LOG-1:0] rd_ptr_reg;
  reg [DEPTH_LOG:0] count_reg;
  reg [DEPTH_LOG:0] err_cnt_reg;
  reg tx_empty_d_reg;
  // ----------------------------------------
  // decode and status
  // ----------------------------------------
  // register bus decode
  wire fifo_en = fifo_ctrl_reg[0];
  wire rx_read = reg_rd && reg_addr == `UIP_OFF_DATA && count_reg != 0;
  wire iir_read = reg_rd && reg_addr == `UIP_OFF_IIR;
  wire lsr_read = reg_rd && reg_addr == `UIP_OFF_LSR;
  wire msr_read = reg_rd && reg_addr == `UIP_OFF_MSR;
  wire thr_write = reg_wr && reg_addr == `UIP_OFF_DATA;
  // writes accepted while room remains, halt or not
  wire rx_push = rx_valid && count_reg != DEPTH;
  wire [10:0] head = mem[rd_ptr_reg];
  // head error bits, zero when empty
  wire [2:0] head_errs = (count_reg != 0) ? head[10:8] : 3'h0;
  wire err_any = err_cnt_reg != 0;
  // ----------------------------------------
  // fifo levels
  // ----------------------------------------
  // nibble times four characters
  // halt level, flow threshold low nibble
  wire [DEPTH_LOG:0] halt_lvl = {{(DEPTH_LOG-5){1'b0}},
    flow_threshold_reg[3:0], 2'b00};
  // resume level, flow threshold high nibble
  wire [DEPTH_LOG:0] resume_lvl = {{(DEPTH_LOG-5){1'b0}},
    flow_threshold_reg[7:4], 2'b00};
  // receive trigger level
  wire [DEPTH_LOG:0] trig_lvl = {{(DEPTH_LOG-5){1'b0}},
    fifo_trigger_reg[7:4], 2'b00};
  // status words
  wire rx_data_avail = count_reg != 0;
  wire [7:0] line_stat = {err_any, tx_empty, tx_empty, head_errs,
    overrun_reg, rx_data_avail};
  wire [7:0] modem_stat = {~pin_s2_reg, modem_chg_reg};
  // flow character compares
  wire halt_match = rx_push && enhanced_feature_reg[1] &&
    rx_char == halt_char_one;
  wire resume_match = rx_push && enhanced_feature_reg[1] &&
    rx_char == resume_char_one;
  wire spec_match = rx_push && enhanced_feature_reg[5] &&
    rx_char == resume_char_one;
  // ----------------------------------------
  // interrupt sources and priority
  // ----------------------------------------
  // each source gated by its enable, pin rise by either pin enable
  wire src_line = irq_enable_reg[`UIP_IE_LINE] && (overrun_reg || err_any);
  // time-out with fifo on and data held
  wire src_tout = irq_enable_reg[`UIP_IE_RXD] && fifo_en && rx_stale &&
    rx_data_avail;
  wire src_rxd = irq_enable_reg[`UIP_IE_RXD] &&
    (fifo_en ? (count_reg > trig_lvl) : rx_data_avail);
  wire src_tx = irq_enable_reg[`UIP_IE_TX] && tx_pend_reg;
  wire src_modem = irq_enable_reg[`UIP_IE_MODEM] && modem_chg_reg != 0;
  wire src_halt = irq_enable_reg[`UIP_IE_HALT] &&
    (halt_pend_reg || spec_pend_reg);
  wire src_pin = (irq_enable_reg[`UIP_IE_RTS] || irq_enable_reg[`UIP_IE_CTS])
    && pin_pend_reg;
  reg [5:0] ident;
  always @* begin
    // codes per source, none as default
    if (src_line)
      ident = `UIP_ID_LINE;
    else if (src_tout)
      ident = `UIP_ID_TOUT;
    else if (src_rxd)
      ident = `UIP_ID_RXD;
    else if (src_tx)
      ident = `UIP_ID_TX;
    else if (src_modem)
      ident = `UIP_ID_MODEM;
    else if (src_halt)
      ident = `UIP_ID_HALT;
    else if (src_pin)
      ident = `UIP_ID_PIN;
    else
      ident = `UIP_ID_NONE;
  end
  // ----------------------------------------
  // receive FIFO with error bits
  // ----------------------------------------
  // pointer logic cleared on reset
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_reg <= {DEPTH_LOG{1'b0}};
      rd_ptr_reg <= {DEPTH_LOG{1'b0}};
      count_reg <= {(DEPTH_LOG+1){1'b0}};
      err_cnt_reg <= {(DEPTH_LOG+1){1'b0}};
    end else begin
      if (rx_push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (rx_read)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg <= count_reg + {{DEPTH_LOG{1'b0}}, rx_push} -
        {{DEPTH_LOG{1'b0}}, rx_read};
      // errors cleared as bad characters are read
      err_cnt_reg <= err_cnt_reg +
        {{DEPTH_LOG{1'b0}}, rx_push && rx_errs != 0} -
        {{DEPTH_LOG{1'b0}}, rx_read && head[10:8] != 0};
    end
  end
  // fifo storage, no reset
  always @(posedge clk_sys) begin
    if (rx_push)
      mem[wr_ptr_reg] <= {rx_errs, rx_char};
  end
  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // control registers cleared, line control
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_enable_reg <= 8'h00;
      fifo_ctrl_reg <= 8'h00;
      line_ctrl_reg <= `UIP_RST_LCR;
      modem_ctrl_reg <= 8'h00;
      enhanced_feature_reg <= 8'h00;
      flow_threshold_reg <= 8'h00;
      fifo_trigger_reg <= 8'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        `UIP_OFF_IER: irq_enable_reg <= reg_wdata;
        `UIP_OFF_FCR: fifo_ctrl_reg <= reg_wdata;
        `UIP_OFF_LCR: line_ctrl_reg <= reg_wdata;
        `UIP_OFF_MCR: modem_ctrl_reg <= reg_wdata;
        `UIP_OFF_EFR: enhanced_feature_reg <= reg_wdata;
        `UIP_OFF_TCR: flow_threshold_reg <= reg_wdata;
        `UIP_OFF_TLR: fifo_trigger_reg <= reg_wdata;
        default: ;
      endcase
    end
  end
  // these keep their values through reset
  always @(posedge clk_sys) begin
    if (reg_wr) begin
      case (reg_addr)
        `UIP_OFF_DLL: divisor_low_byte <= reg_wdata;
        `UIP_OFF_DLM: divisor_high_byte <= reg_wdata;
        `UIP_OFF_SPR: scratch_reg <= reg_wdata;
        `UIP_OFF_CHR: resume_char_one <= reg_wdata;
        `UIP_OFF_EVT: halt_char_one <= reg_wdata;
        default: ;
      endcase
    end
  end
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_s1_reg <= 4'hF;
      pin_s2_reg <= 4'hF;
      fc_s1_reg <= 2'b11;
      fc_s2_reg <= 2'b11;
      fc_d_reg <= 2'b11;
    end else begin
      pin_s1_reg <= modem_pins_n;
      pin_s2_reg <= pin_s1_reg;
      fc_s1_reg <= {rts_pin_n, cts_pin_n};
      fc_s2_reg <= fc_s1_reg;
      fc_d_reg <= fc_s2_reg;
    end
  end
  reg [3:0] pin_d_reg;
  wire [3:0] pin_change = pin_s2_reg ^ pin_d_reg;
  wire pin_rise = |(fc_s2_reg & ~fc_d_reg);
  wire tx_rise = tx_empty && !tx_empty_d_reg;
  // ----------------------------------------
  // sticky interrupt sources
  // ----------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_d_reg <= 4'hF;
      modem_chg_reg <= 4'h0;
      overrun_reg <= 1'b0;
      tx_pend_reg <= 1'b0;
      tx_empty_d_reg <= 1'b1;
      halt_pend_reg <= 1'b0;
      spec_pend_reg <= 1'b0;
      pin_pend_reg <= 1'b0;
    end else begin
      pin_d_reg <= pin_s2_reg;
      tx_empty_d_reg <= tx_empty;
      // modem change cleared by status read
      modem_chg_reg <= (msr_read ? 4'h0 : modem_chg_reg) | pin_change;
      // overrun cleared by line status read
      overrun_reg <= (overrun_reg && !lsr_read) || rx_overrun;
      // cleared by ident read or transmit write
      tx_pend_reg <= (tx_pend_reg && !(iir_read && ident == `UIP_ID_TX)
        && !thr_write) || (fifo_en ? tx_fifo_trig : tx_rise);
      // halt char sets, resume char clears
      if (halt_match)
        halt_pend_reg <= 1'b1;
      else if (resume_match)
        halt_pend_reg <= 1'b0;
      // special char cleared on status read
      spec_pend_reg <= (spec_pend_reg && !lsr_read &&
        !(iir_read && ident == `UIP_ID_HALT)) || spec_match;
      // pin rise cleared by ident read
      pin_pend_reg <= (pin_pend_reg && !(iir_read && ident == `UIP_ID_PIN))
        || pin_rise;
    end
  end
  // ----------------------------------------
  // flow character transmit request
  // ----------------------------------------
  reg sent_halt_reg;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sent_halt_reg <= 1'b0;
      flow_char_req <= 1'b0;
      flow_char <= 8'h00;
    end else if (flow_char_req) begin
      if (flow_char_done)
        flow_char_req <= 1'b0;
    end else if (enhanced_feature_reg[3]) begin
      if (!sent_halt_reg && count_reg > halt_lvl) begin
        sent_halt_reg <= 1'b1;
        flow_char_req <= 1'b1;
        flow_char <= halt_char_one;
      // resume once drained to resume level
      end else if (sent_halt_reg && count_reg <= resume_lvl) begin
        sent_halt_reg <= 1'b0;
        flow_char_req <= 1'b1;
        flow_char <= resume_char_one;
      end
    end
  end
  // ----------------------------------------
  // outputs and read port
  // ----------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      txd <= 1'b1;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
      rx_dma_request_n <= 1'b1;
      tx_dma_request_n <= 1'b0;
      irq <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      txd <= !line_ctrl_reg[6];
      rts_n <= !modem_ctrl_reg[1];
      dtr_n <= !modem_ctrl_reg[0];
      rx_dma_request_n <= !rx_data_avail;
      tx_dma_request_n <= !tx_empty;
      // all enables clear means no interrupt
      irq <= ident != `UIP_ID_NONE;
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `UIP_OFF_DATA: reg_rdata <= head[7:0];
          `UIP_OFF_IER: reg_rdata <= irq_enable_reg;
          `UIP_OFF_IIR: reg_rdata <= {2'b00, ident};
          `UIP_OFF_LCR: reg_rdata <= line_ctrl_reg;
          `UIP_OFF_MCR: reg_rdata <= modem_ctrl_reg;
          `UIP_OFF_LSR: reg_rdata <= line_stat;
          `UIP_OFF_MSR: reg_rdata <= modem_stat;
          `UIP_OFF_SPR: reg_rdata <= scratch_reg;
          `UIP_OFF_DLL: reg_rdata <= divisor_low_byte;
          `UIP_OFF_DLM: reg_rdata <= divisor_high_byte;
          `UIP_OFF_EFR: reg_rdata <= enhanced_feature_reg;
          `UIP_OFF_TCR: reg_rdata <= flow_threshold_reg;
          `UIP_OFF_TLR: reg_rdata <= fifo_trigger_reg;
          `UIP_OFF_CHR: reg_rdata <= resume_char_one;
          `UIP_OFF_EVT: reg_rdata <= halt_char_one;
          default: reg_rdata <= fifo_ctrl_reg;
        endcase
      end
    end
  end
endmodule // uip_core
`default_nettype wire

//--- design/uip_regs.vh
`ifndef UIP_REGS_VH
`define UIP_REGS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define UIP_ADDR_W 4
`define UIP_OFF_DATA 4'h0
`define UIP_OFF_IER 4'h1
`define UIP_OFF_IIR 4'h2
`define UIP_OFF_LCR 4'h3
`define UIP_OFF_MCR 4'h4
`define UIP_OFF_LSR 4'h5
`define UIP_OFF_MSR 4'h6
`define UIP_OFF_SPR 4'h7
`define UIP_OFF_DLL 4'h8
`define UIP_OFF_DLM 4'h9
`define UIP_OFF_EFR 4'hA
`define UIP_OFF_TCR 4'hB
`define UIP_OFF_TLR 4'hC
`define UIP_OFF_CHR 4'hD
`define UIP_OFF_FCR 4'hE
`define UIP_OFF_EVT 4'hF
// ----------------------------------------
// reset values
// ----------------------------------------
`define UIP_RST_LCR 8'h1D
`define UIP_RST_LSR 8'h60
`define UIP_RST_IIR 8'h01
// ----------------------------------------
// ident codes
// ----------------------------------------
`define UIP_ID_NONE 6'h01
`define UIP_ID_LINE 6'h06
`define UIP_ID_TOUT 6'h0C
`define UIP_ID_RXD 6'h04
`define UIP_ID_TX 6'h02
`define UIP_ID_MODEM 6'h00
`define UIP_ID_HALT 6'h10
`define UIP_ID_PIN 6'h20
// ----------------------------------------
// enable bit positions
// ----------------------------------------
`define UIP_IE_RXD 0
`define UIP_IE_TX 1
`define UIP_IE_LINE 2
`define UIP_IE_MODEM 3
`define UIP_IE_HALT 5
`define UIP_IE_RTS 6
`define UIP_IE_CTS 7
// threshold fields count four characters per step
`define UIP_THR_SHIFT 2
`endif

//--- testbench/uip_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "uip_regs.vh"
module uip_monitor #(
  parameter DEPTH_LOG = 6
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic rx_overrun,
  input wire logic rx_stale,
  input wire logic tx_empty,
  input wire logic rts_pin_n,
  input wire logic flow_char_done,
  input wire logic flow_char_req,
  input wire logic [7:0] flow_char,
  input wire logic irq,
  input wire logic txd,
  input wire logic rts_n,
  input wire logic dtr_n,
  input wire logic rx_dma_request_n,
  input wire logic tx_dma_request_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // shadows of enable and fifo writes
  // ----------------------------------------
  logic [7:0] ier_sh;
  logic fifo_on;
  logic wr_seen;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ier_sh <= 8'h00;
      fifo_on <= 1'h0;
      wr_seen <= 1'h0;
    end else if (reg_wr) begin
      wr_seen <= 1'h1;
      if (reg_addr == `UIP_OFF_IER)
        ier_sh <= reg_wdata;
      if (reg_addr == `UIP_OFF_FCR)
        fifo_on <= reg_wdata[0];
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  // no clearing cause in this cycle
  sequence quiet;
    !reg_rd && !reg_wr && !rx_valid && $stable(rx_stale)
      && $stable(tx_empty);
  endsequence
  a_reset_pins: assert property (
    $rose(rstn) |-> txd && rts_n && dtr_n && rx_dma_request_n
      && !tx_dma_request_n) else $error("pins not at reset levels");
  a_ident_idle: assert property (
    reg_rd && reg_addr == `UIP_OFF_IIR && !wr_seen |=> reg_rdata == 8'h01)
    else $error("ident not idle after reset");
  a_line_reset: assert property (
    reg_rd && reg_addr == `UIP_OFF_LCR && !wr_seen |=> reg_rdata == 8'h1D)
    else $error("line control not at reset value");
  a_all_off: assert property (
    (ier_sh & 8'hEF) == 8'h00 && ($past(ier_sh) & 8'hEF) == 8'h00 |-> !irq)
    else $error("irq with all enables clear");
  a_rx_raise: assert property (
    rx_valid && ier_sh[`UIP_IE_RXD] && !fifo_on |-> ##[1:3] irq)
    else $error("no irq on received data");
  a_overrun_raise: assert property (
    rx_overrun && ier_sh[`UIP_IE_LINE] |-> ##[1:3] irq)
    else $error("no irq on overrun");
  a_pin_raise: assert property (
    $rose(rts_pin_n) && ier_sh[`UIP_IE_RTS] |-> ##[1:8] irq)
    else $error("no irq on pin rise");
  a_flow_hold: assert property (
    flow_char_req && !flow_char_done |=> flow_char_req && $stable(flow_char))
    else $error("flow request dropped early");
  a_irq_holds: assert property (
    (quiet ##1 (quiet and irq)) |=> irq)
    else $error("irq dropped without clearing");
endmodule // uip_monitor
bind uip_core uip_monitor #(.DEPTH_LOG(DEPTH_LOG)) u_uip_monitor (
  .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_overrun(rx_overrun),
  .rx_stale(rx_stale), .tx_empty(tx_empty), .rts_pin_n(rts_pin_n),
  .flow_char_done(flow_char_done), .flow_char_req(flow_char_req),
  .flow_char(flow_char), .irq(irq), .txd(txd), .rts_n(rts_n),
  .dtr_n(dtr_n), .rx_dma_request_n(rx_dma_request_n),
  .tx_dma_request_n(tx_dma_request_n));
`default_nettype wire

//--- testbench/uip_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module uip_line_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic slow,
  input wire logic flow_char_req,
  input wire logic [7:0] flow_char,
  output logic flow_char_done,
  output logic [7:0] last_sent,
  output logic [7:0] sent_count
);
  logic [4:0] busy_cnt;
  // serialise one flow character per request, prompt or slow
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flow_char_done <= 1'h0;
      busy_cnt <= 5'h00;
      last_sent <= 8'h00;
      sent_count <= 8'h00;
    end else begin
      flow_char_done <= 1'h0;
      if (flow_char_req && !flow_char_done) begin
        if (busy_cnt == (slow ? 5'h14 : 5'h01)) begin
          flow_char_done <= 1'h1;
          last_sent <= flow_char;
          sent_count <= sent_count + 8'h01;
          busy_cnt <= 5'h00;
        end else begin
          busy_cnt <= busy_cnt + 5'h01;
        end
      end
    end
  end
endmodule // uip_line_model
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "uip_regs.vh"
module testbench;
  logic clk_sys = 1'h0;
  logic rstn = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0, reg_rd = 1'h0, rx_valid = 1'h0, rx_overrun = 1'h0;
  logic [7:0] rx_char = 8'h00;
  logic [2:0] rx_errs = 3'h0;
  logic tx_empty = 1'h1, rts_pin_n = 1'h1, slow = 1'h0, rx_stale = 1'h0;
  logic tx_fifo_trig = 1'h0;
  logic [3:0] modem_pins_n = 4'hF;
  wire [7:0] reg_rdata, flow_char, last_sent, sent_count;
  wire flow_char_done, flow_char_req, irq, txd, rts_n, dtr_n, rxr_n, txr_n;
  int fails = 0, check_count = 0, cyc = 0, i;
  logic [7:0] v;
  always #10 clk_sys = ~clk_sys;
  uip_core #(.DEPTH_LOG(6)) u_uip_core (.clk_sys(clk_sys), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
    .rx_char(rx_char), .rx_errs(rx_errs), .rx_overrun(rx_overrun),
    .rx_stale(rx_stale), .tx_fifo_trig(tx_fifo_trig), .tx_empty(tx_empty),
    .modem_pins_n(modem_pins_n), .rts_pin_n(rts_pin_n), .cts_pin_n(1'h1),
    .flow_char_done(flow_char_done), .flow_char_req(flow_char_req),
    .flow_char(flow_char), .irq(irq), .txd(txd), .rts_n(rts_n),
    .dtr_n(dtr_n), .rx_dma_request_n(rxr_n), .tx_dma_request_n(txr_n));
  uip_line_model u_uip_line_model (.clk_sys(clk_sys), .rstn(rstn),
    .slow(slow), .flow_char_req(flow_char_req), .flow_char(flow_char),
    .flow_char_done(flow_char_done), .last_sent(last_sent),
    .sent_count(sent_count));
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [7:0] s, e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 v = reg_rdata;
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    rd(a);
    chk($sformatf("register %h", a), v, e);
  endtask
  task automatic push(input logic [7:0] c, input logic [2:0] e);
    @(posedge clk_sys);
    rx_valid <= 1'h1;
    rx_char <= c;
    rx_errs <= e;
    @(posedge clk_sys);
    rx_valid <= 1'h0;
  endtask
  // wait bounded for irq or flow request to reach a level
  task automatic wt(input bit sel, input logic e);
    #1;
    for (int k = 0; k < 40; k++) begin
      if ((sel ? flow_char_req : irq) === e)
        break;
      @(posedge clk_sys);
      #1;
    end
    chk(sel ? "flow request" : "irq", {7'h00, sel ? flow_char_req : irq},
      {7'h00, e});
  endtask
  task automatic do_reset();
    rstn <= 1'h0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'h1;
  endtask
  task automatic print_verdict();
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    do_reset();
    for (i = 0; i < 16; i++)
      wr(i[3:0], 8'h5A ^ i[7:0]);
    do_reset();
    for (i = 1; i < 16; i++) begin
      rd(i[3:0]);
      if (i == 6)
        chk("modem change bits", v & 8'h0F, 8'h00);
      else if (i inside {7, 8, 9, 13, 15})
        chk("kept register", v, 8'h5A ^ i[7:0]);
      else
        chk("reset register", v, i == 2 ? 8'h01 : i == 3 ? 8'h1D :
          i == 5 ? 8'h60 : 8'h00);
    end
    // overrun while disabled, then enabled
    @(posedge clk_sys) rx_overrun <= 1'h1;
    @(posedge clk_sys) rx_overrun <= 1'h0;
    repeat (4) @(posedge clk_sys);
    wt(0, 1'h0);
    wr(`UIP_OFF_IER, 8'h04);
    wt(0, 1'h1);
    rc(`UIP_OFF_IIR, 8'h06);
    rc(`UIP_OFF_LSR, 8'h62);
    rc(`UIP_OFF_IIR, 8'h01);
    // modem change
    wr(`UIP_OFF_IER, 8'h08);
    modem_pins_n <= 4'hE;
    wt(0, 1'h1);
    rc(`UIP_OFF_IIR, 8'h00);
    rd(`UIP_OFF_MSR);
    rc(`UIP_OFF_IIR, 8'h01);
    // error char beats data ready
    wr(`UIP_OFF_IER, 8'h05);
    push(8'h33, 3'h2);
    wt(0, 1'h1);
    rc(`UIP_OFF_IIR, 8'h06);
    rc(`UIP_OFF_LSR, 8'hE9);
    rc(`UIP_OFF_DATA, 8'h33);
    rc(`UIP_OFF_LSR, 8'h60);
    rc(`UIP_OFF_IIR, 8'h01);
    push(8'h44, 3'h0);
    wt(0, 1'h1);
    rc(`UIP_OFF_IIR, 8'h04);
    rc(`UIP_OFF_DATA, 8'h44);
    rc(`UIP_OFF_IIR, 8'h01);
    // holding empty
    tx_empty <= 1'h0;
    wr(`UIP_OFF_IER, 8'h02);
    tx_empty <= 1'h1;
    wt(0, 1'h1);
    rc(`UIP_OFF_IIR, 8'h02);
    rc(`UIP_OFF_IIR, 8'h01);
    // pin rise
    wr(`UIP_OFF_IER, 8'h40);
    rts_pin_n <= 1'h0;
    repeat (6) @(posedge clk_sys);
    rts_pin_n <= 1'h1;
    wt(0, 1'h1);
    rc(`UIP_OFF_IIR, 8'h20);
    rc(`UIP_OFF_IIR, 8'h01);
    // halt then resume, then special char
    wr(`UIP_OFF_CHR, 8'h0D);
    wr(`UIP_OFF_EVT, 8'h0F);
    wr(`UIP_OFF_EFR, 8'h02);
    wr(`UIP_OFF_IER, 8'h20);
    push(8'h0F, 3'h0);
    wt(0, 1'h1);
    rc(`UIP_OFF_IIR, 8'h10);
    push(8'h0D, 3'h0);
    wt(0, 1'h0);
    wr(`UIP_OFF_EFR, 8'h20);
    push(8'h0D, 3'h0);
    wt(0, 1'h1);
    rc(`UIP_OFF_IIR, 8'h10);
    rd(`UIP_OFF_LSR);
    rc(`UIP_OFF_IIR, 8'h01);
    for (i = 0; i < 4; i++)
      rd(`UIP_OFF_DATA);
    // time-out and fifo transmit trigger
    wr(`UIP_OFF_FCR, 8'h01);
    wr(`UIP_OFF_IER, 8'h01);
    push(8'h55, 3'h0);
    rx_stale <= 1'h1;
    wt(0, 1'h1);
    rc(`UIP_OFF_IIR, 8'h0C);
    rx_stale <= 1'h0;
    rc(`UIP_OFF_DATA, 8'h55);
    rc(`UIP_OFF_IIR, 8'h01);
    wr(`UIP_OFF_IER, 8'h02);
    @(posedge clk_sys) tx_fifo_trig <= 1'h1;
    @(posedge clk_sys) tx_fifo_trig <= 1'h0;
    wt(0, 1'h1);
    wr(`UIP_OFF_DATA, 8'h00);
    rc(`UIP_OFF_IIR, 8'h01);
    // halt and resume thresholds, slow far side
    wr(`UIP_OFF_IER, 8'h00);
    wr(`UIP_OFF_FCR, 8'h01);
    wr(`UIP_OFF_EFR, 8'h08);
    wr(`UIP_OFF_TCR, 8'h8F);
    slow <= 1'h1;
    repeat (59) push(8'h41, 3'h0);
    wt(1, 1'h0);
    repeat (2) push(8'h42, 3'h0);
    wt(1, 1'h1);
    chk("halt char", flow_char, 8'h0F);
    push(8'h43, 3'h0);
    wt(1, 1'h0);
    chk("sent char", last_sent, 8'h0F);
    repeat (29) rd(`UIP_OFF_DATA);
    wt(1, 1'h0);
    slow <= 1'h0;
    rd(`UIP_OFF_DATA);
    wt(1, 1'h1);
    chk("resume char", flow_char, 8'h0D);
    wt(1, 1'h0);
    chk("sent count", sent_count, 8'h02);
    repeat (31) rd(`UIP_OFF_DATA);
    rc(`UIP_OFF_DATA, 8'h43);
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
